/* common/vit_pkg.sv */
package vit_pkg;

  // Register byte offsets
  localparam logic [11:0] VIT_OFS_ENABLE = 12'h000;
  localparam logic [11:0] VIT_OFS_STATUS = 12'h004;
  localparam logic [11:0] VIT_OFS_SVC = 12'h008;

  // Maskable sources, status and enable bit positions (lowest priority first)
  localparam int VIT_NUM_IRQ = 10;
  localparam int VIT_BIT_EXT_A = 0;
  localparam int VIT_BIT_TEST = 1;
  localparam int VIT_BIT_EXT_B = 2;
  localparam int VIT_BIT_TIMER = 3;
  localparam int VIT_BIT_SB_IN = 4;
  localparam int VIT_BIT_SB_OUT = 5;
  localparam int VIT_BIT_SA_IN = 6;
  localparam int VIT_BIT_SA_OUT = 7;
  localparam int VIT_BIT_HOST_IN = 8;
  localparam int VIT_BIT_HOST_OUT = 9;

  // Status bits that software clears by writing 1
  localparam logic [9:0] VIT_W1C_MASK = 10'h00D;

  // Service state register fields
  localparam int VIT_SVC_ACK_BIT = 0;
  localparam int VIT_SVC_TRAP_BIT = 1;
  localparam int VIT_SVC_BUSY_BIT = 2;
  localparam int VIT_SVC_CODE_LSB = 4;

  // Reset values
  localparam logic [9:0] VIT_ENABLE_RST = 10'h000;
  localparam logic [9:0] VIT_STATUS_RST = 10'h000;
  localparam logic [3:0] VIT_CODE_NONE = 4'h0;

  // Trap vectors and codes
  localparam logic [15:0] VIT_VEC_USER_TRAP = 16'h0046;
  localparam logic [15:0] VIT_VEC_DEBUG_TRAP = 16'h0003;
  localparam logic [3:0] VIT_CODE_USER_TRAP = 4'h7;

  // Trap latency
  localparam int VIT_TRAP_LAT_CYC = 4;
  localparam logic [2:0] VIT_TRAP_CNT_LAST = 3'(VIT_TRAP_LAT_CYC - 1);

  typedef enum logic [2:0] {
    VIT_TRAP_IDLE = 3'b001,
    VIT_TRAP_WAIT = 3'b010,
    VIT_TRAP_ACTIVE = 3'b100
  } vit_trap_st_t;

  typedef enum logic [1:0] {
    VIT_SVC_IDLE = 2'b01,
    VIT_SVC_ACTIVE = 2'b10
  } vit_svc_st_t;

  // Request index 0 is the software interrupt, 1..10 the status bits
  function automatic logic [15:0] vit_vector(input logic [3:0] idx);
    case (idx)
      4'h0: vit_vector = 16'h0002;
      4'h1: vit_vector = 16'h0001;
      4'h2: vit_vector = 16'h0042;
      4'h3: vit_vector = 16'h0004;
      4'h4: vit_vector = 16'h0010;
      4'h5: vit_vector = 16'h0014;
      4'h6: vit_vector = 16'h0018;
      4'h7: vit_vector = 16'h002C;
      4'h8: vit_vector = 16'h0030;
      4'h9: vit_vector = 16'h0034;
      4'hA: vit_vector = 16'h0038;
      default: vit_vector = 16'h0000;
    endcase
  endfunction

  function automatic logic [3:0] vit_code(input logic [3:0] idx);
    case (idx)
      4'h0: vit_code = 4'h1;
      4'h1: vit_code = 4'h2;
      4'h2: vit_code = 4'h8;
      4'h3: vit_code = 4'h9;
      4'h4: vit_code = 4'hC;
      4'h5: vit_code = 4'hD;
      4'h6: vit_code = 4'hE;
      4'h7: vit_code = 4'h3;
      4'h8: vit_code = 4'h4;
      4'h9: vit_code = 4'h5;
      4'hA: vit_code = 4'h6;
      default: vit_code = 4'h0;
    endcase
  endfunction

endpackage

/* src/vit_arbiter.sv */
module vit_arbiter
  import vit_pkg::*;
(
  // Requests, higher index wins
  input wire logic [VIT_NUM_IRQ:0] req,
  // Winner
  output logic valid,
  output logic [3:0] idx
);

  always_comb begin
    valid = 1'b0;
    idx = 4'h0;
    for (int i = 0; i <= VIT_NUM_IRQ; i++) begin
      if (req[i]) begin
        valid = 1'b1;
        idx = 4'(i);
      end
    end
  end

endmodule

/* src/vit_top.sv */
// Notes on behaviour
// - Ten maskable sources, software interrupt, two traps
// - Software interrupt, traps: no mask, no flag
// - Service entry raises acknowledge, drives code
// - Interrupts taken after interruptible instruction only
// - Simultaneous pending interrupts served by priority
// - Routines, branches, loops, pointer decrements uninterruptible
// - Traps ignore interruptibility
// - Further traps ignored during trap service
// - Flag shows event regardless of enable
// - Disabled interrupt never serviced, flag stays
// - Enable bit one unmasks, zero masks
// - Interrupt taken only when none in service
// - Masked latched flag served once unmasked
// - Acknowledge high during service, low on return unless a user or debug trap fires in the same cycle
// - Debug traps leave acknowledge and code alone
// - Host flags cleared by data accesses
// - Serial flags clear one cycle after access
// - Test port flag cleared by data read
// - Write one clears pin and timer flags
// - Return clears served pin or timer flag
// - User trap 0x46, debug trap 0x3
// - Trap gains control after four cycles
// - Trap pin input at reset, forces trap
module vit_top
  import vit_pkg::*;
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Sequencer
  input wire logic instr_done,
  input wire logic instr_is_branch,
  input wire logic instr_is_cache_loop,
  input wire logic instr_is_ptr_dec_only,
  input wire logic return_issued,
  input wire logic sw_irq_req,
  input wire logic debug_trap_req,
  output logic take_valid,
  output logic [15:0] take_vector,
  // Interrupt events
  input wire logic external_irq_pin_a,
  input wire logic external_irq_pin_b,
  input wire logic timer_irq,
  input wire logic test_port_irq,
  input wire logic serial_a_input_full_irq,
  input wire logic serial_a_output_empty_irq,
  input wire logic serial_b_input_full_irq,
  input wire logic serial_b_output_empty_irq,
  input wire logic host_port_input_full_irq,
  input wire logic host_port_output_empty_irq,
  // Peripheral data accesses
  input wire logic host_in_data_read,
  input wire logic host_out_data_write,
  input wire logic serial_a_in_data_read,
  input wire logic serial_a_out_data_write,
  input wire logic serial_b_in_data_read,
  input wire logic serial_b_out_data_write,
  input wire logic test_port_data_read,
  // Trap pin
  input wire logic trap_pin_in,
  input wire logic trap_pin_drive,
  output logic trap_pin_out,
  output logic trap_pin_oe,
  // Service status pins
  output logic service_acknowledge_out,
  output logic [3:0] service_code_pins,
  output logic trap_active
);

  logic [9:0] enable_r;
  logic [9:0] status_r;
  logic [9:0] status_nxt;
  logic sw_pend_r;
  logic [3:0] ser_clr_dly_r;
  logic trap_pin_prev_r;
  logic [2:0] trap_cnt_r;
  logic trap_user_r;
  vit_trap_st_t trap_st_r;
  vit_svc_st_t svc_st_r;
  logic [3:0] svc_idx_r;
  logic take_is_irq_r;
  logic [3:0] take_idx_r;
  logic [31:0] prdata_r;
  logic pready_r;
  logic pslverr_r;
  logic ack_r;
  logic [3:0] code_r;
  logic take_valid_r;
  logic [15:0] take_vector_r;
  logic trap_oe_r;

  logic [9:0] events;
  logic [9:0] clr_access;
  logic [9:0] clr_return;
  logic [9:0] clr_w1c;
  logic apb_write;
  logic instr_ok;
  logic arb_valid;
  logic [3:0] arb_idx;
  logic trap_new;
  logic user_trap_req;
  logic trap_fire;
  logic irq_take;
  logic svc_return;
  logic trap_return;

  assign apb_write = psel & penable & pready_r & pwrite;

  assign events = {host_port_output_empty_irq, host_port_input_full_irq,
                   serial_a_output_empty_irq, serial_a_input_full_irq,
                   serial_b_output_empty_irq, serial_b_input_full_irq,
                   timer_irq, external_irq_pin_b, test_port_irq, external_irq_pin_a};

  // immediate access clears, delayed serial clears
  assign clr_access = {host_out_data_write, host_in_data_read,
                       ser_clr_dly_r, 2'b00, test_port_data_read, 1'b0};

  assign clr_w1c = (apb_write && paddr == VIT_OFS_STATUS) ? (pwdata[9:0] & VIT_W1C_MASK) : 10'h000;

  assign svc_return = return_issued & (svc_st_r == VIT_SVC_ACTIVE) & (trap_st_r != VIT_TRAP_ACTIVE);
  assign trap_return = return_issued & (trap_st_r == VIT_TRAP_ACTIVE);

  // return clears served pin or timer flag
  always_comb begin
    clr_return = 10'h000;
    if (svc_return && svc_idx_r != 4'h0) begin
      clr_return[svc_idx_r - 4'h1] = VIT_W1C_MASK[svc_idx_r - 4'h1];
    end
  end

  // Set wins over every clear
  assign status_nxt = (status_r & ~(clr_access | clr_w1c | clr_return)) | events;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status_r <= VIT_STATUS_RST;
    end else begin
      status_r <= status_nxt;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ser_clr_dly_r <= 4'h0;
    end else begin
      ser_clr_dly_r <= {serial_a_out_data_write, serial_a_in_data_read,
                        serial_b_out_data_write, serial_b_in_data_read};
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      enable_r <= VIT_ENABLE_RST;
    end else if (apb_write && paddr == VIT_OFS_ENABLE) begin
      enable_r <= pwdata[9:0];
    end
  end

  // APB: no wait state, response built in setup cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r <= 32'h0000_0000;
    end else begin
      pready_r <= psel & ~penable;
      if (psel && !penable) begin
        pslverr_r <= 1'b0;
        prdata_r <= 32'h0000_0000;
        if (paddr == VIT_OFS_ENABLE) begin
          prdata_r[9:0] <= enable_r;
        end else if (paddr == VIT_OFS_STATUS) begin
          prdata_r[9:0] <= status_r;
        end else if (paddr == VIT_OFS_SVC) begin
          prdata_r[VIT_SVC_ACK_BIT] <= ack_r;
          prdata_r[VIT_SVC_TRAP_BIT] <= (trap_st_r != VIT_TRAP_IDLE);
          prdata_r[VIT_SVC_BUSY_BIT] <= (svc_st_r == VIT_SVC_ACTIVE);
          prdata_r[VIT_SVC_CODE_LSB +: 4] <= code_r;
        end else begin
          pslverr_r <= 1'b1;
        end
      end else begin
        pslverr_r <= 1'b0;
      end
    end
  end

  // software interrupt pending, no flag, no mask
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sw_pend_r <= 1'b0;
    end else if (sw_irq_req) begin
      sw_pend_r <= 1'b1;
    end else if (irq_take && arb_idx == 4'h0) begin
      sw_pend_r <= 1'b0;
    end
  end

  vit_arbiter u_arb (
    .req({status_r & enable_r, sw_pend_r}),
    .valid(arb_valid),
    .idx(arb_idx)
  );

  assign instr_ok = instr_done & ~instr_is_branch & ~instr_is_cache_loop & ~instr_is_ptr_dec_only &
                    (svc_st_r == VIT_SVC_IDLE);

  // only when idle and no trap in progress
  assign irq_take = instr_ok & arb_valid & (trap_st_r == VIT_TRAP_IDLE);

  // rising trap pin forces user trap
  assign user_trap_req = trap_pin_in & ~trap_pin_prev_r;
  assign trap_new = (user_trap_req | debug_trap_req) & (trap_st_r == VIT_TRAP_IDLE);
  assign trap_fire = (trap_st_r == VIT_TRAP_WAIT) && (trap_cnt_r == VIT_TRAP_CNT_LAST);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      trap_pin_prev_r <= 1'b0;
    end else begin
      trap_pin_prev_r <= trap_pin_in;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      trap_st_r <= VIT_TRAP_IDLE;
      trap_cnt_r <= 3'h0;
      trap_user_r <= 1'b0;
    end else begin
      case (trap_st_r)
        VIT_TRAP_IDLE: begin
          if (trap_new) begin
            trap_st_r <= VIT_TRAP_WAIT;
            trap_cnt_r <= 3'h0;
            trap_user_r <= user_trap_req;
          end
        end
        VIT_TRAP_WAIT: begin
          if (trap_fire) begin
            trap_st_r <= VIT_TRAP_ACTIVE;
          end else begin
            trap_cnt_r <= trap_cnt_r + 3'h1;
          end
        end
        VIT_TRAP_ACTIVE: begin
          if (return_issued) begin
            trap_st_r <= VIT_TRAP_IDLE;
          end
        end
        default: trap_st_r <= VIT_TRAP_IDLE;
      endcase
    end
  end

  // Interrupt service state; a user trap abandons the routine
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      svc_st_r <= VIT_SVC_IDLE;
      svc_idx_r <= 4'h0;
    end else begin
      case (svc_st_r)
        VIT_SVC_IDLE: begin
          if (irq_take) begin
            svc_st_r <= VIT_SVC_ACTIVE;
            svc_idx_r <= arb_idx;
          end
        end
        VIT_SVC_ACTIVE: begin
          if (svc_return || (trap_return && trap_user_r)) begin
            svc_st_r <= VIT_SVC_IDLE;
          end
        end
        default: svc_st_r <= VIT_SVC_IDLE;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ack_r <= 1'b0;
      code_r <= VIT_CODE_NONE;
    end else if (trap_fire) begin
      if (trap_user_r) begin
        ack_r <= 1'b1;
        code_r <= VIT_CODE_USER_TRAP;
      end
    end else if (irq_take) begin
      ack_r <= 1'b1;
      code_r <= vit_code(arb_idx);
    end else if (svc_return || (trap_return && trap_user_r)) begin
      ack_r <= 1'b0;
      code_r <= VIT_CODE_NONE;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      take_valid_r <= 1'b0;
      take_vector_r <= 16'h0000;
      take_is_irq_r <= 1'b0;
      take_idx_r <= 4'h0;
    end else begin
      take_valid_r <= trap_fire | irq_take;
      take_is_irq_r <= irq_take & ~trap_fire;
      take_idx_r <= arb_idx;
      if (trap_fire) begin
        take_vector_r <= trap_user_r ? VIT_VEC_USER_TRAP : VIT_VEC_DEBUG_TRAP;
      end else if (irq_take) begin
        take_vector_r <= vit_vector(arb_idx);
      end
    end
  end

  // pin stays input until told to drive
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      trap_oe_r <= 1'b0;
    end else begin
      trap_oe_r <= trap_pin_drive;
    end
  end

  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign take_valid = take_valid_r;
  assign take_vector = take_vector_r;
  assign trap_pin_out = trap_oe_r;
  assign trap_pin_oe = trap_oe_r;
  assign service_acknowledge_out = ack_r;
  assign service_code_pins = code_r;
  assign trap_active = (trap_st_r == VIT_TRAP_ACTIVE);

  property p_trap_latency;
    @(posedge pclk) disable iff (!presetn)
    (trap_st_r == VIT_TRAP_IDLE && trap_new) |-> ##5 (take_valid_r && !take_is_irq_r);
  endproperty
  a_trap_latency: assert property (p_trap_latency) else $error("trap not taken after four cycles");

  property p_irq_point;
    @(posedge pclk) disable iff (!presetn)
    (take_valid_r && take_is_irq_r) |-> $past(instr_ok);
  endproperty
  a_irq_point: assert property (p_irq_point) else $error("interrupt taken at a non-interruptible point");

  property p_irq_idle;
    @(posedge pclk) disable iff (!presetn)
    (take_valid_r && take_is_irq_r) |-> $past(svc_st_r) == VIT_SVC_IDLE;
  endproperty
  a_irq_idle: assert property (p_irq_idle) else $error("interrupt taken while another in service");

  property p_irq_code;
    @(posedge pclk) disable iff (!presetn)
    (take_valid_r && take_is_irq_r) |-> (ack_r && code_r == vit_code(take_idx_r) &&
                                          take_vector_r == vit_vector(take_idx_r));
  endproperty
  a_irq_code: assert property (p_irq_code) else $error("acknowledge or code wrong on entry");

  property p_masked;
    @(posedge pclk) disable iff (!presetn)
    (take_valid_r && take_is_irq_r && take_idx_r != 4'h0) |->
      |($past(enable_r) & (10'h001 << (take_idx_r - 4'h1)));
  endproperty
  a_masked: assert property (p_masked) else $error("masked interrupt serviced");

  property p_trap_ignored;
    @(posedge pclk) disable iff (!presetn)
    (trap_st_r == VIT_TRAP_ACTIVE && !return_issued) |=> trap_st_r == VIT_TRAP_ACTIVE;
  endproperty
  a_trap_ignored: assert property (p_trap_ignored) else $error("trap accepted during trap service");

  property p_debug_quiet;
    @(posedge pclk) disable iff (!presetn)
    (trap_fire && !trap_user_r) |=> ($stable(ack_r) && $stable(code_r));
  endproperty
  a_debug_quiet: assert property (p_debug_quiet) else $error("debug trap changed acknowledge pins");

  property p_ack_return;
    @(posedge pclk) disable iff (!presetn)
    (svc_return && !trap_fire) |=> (!ack_r && svc_st_r == VIT_SVC_IDLE);
  endproperty
  a_ack_return: assert property (p_ack_return) else $error("acknowledge still high after return");

  property p_w1c;
    @(posedge pclk) disable iff (!presetn)
    (apb_write && paddr == VIT_OFS_STATUS && pwdata[VIT_BIT_EXT_A] && !external_irq_pin_a) |=>
      !status_r[VIT_BIT_EXT_A];
  endproperty
  a_w1c: assert property (p_w1c) else $error("write one did not clear pin flag");

  property p_serial_delay;
    @(posedge pclk) disable iff (!presetn)
    (serial_a_in_data_read && !serial_a_input_full_irq && status_r[VIT_BIT_SA_IN]) ##1
      !serial_a_input_full_irq |-> status_r[VIT_BIT_SA_IN] ##1 !status_r[VIT_BIT_SA_IN];
  endproperty
  a_serial_delay: assert property (p_serial_delay) else $error("serial flag cleared at wrong cycle");

  property p_flag_set;
    @(posedge pclk) disable iff (!presetn)
    host_port_input_full_irq |=> status_r[VIT_BIT_HOST_IN];
  endproperty
  a_flag_set: assert property (p_flag_set) else $error("event did not set its flag");

  c_irq: cover property (@(posedge pclk) disable iff (!presetn) take_valid_r && take_is_irq_r);
  c_user_trap: cover property (@(posedge pclk) disable iff (!presetn) trap_fire && trap_user_r);
  c_debug_trap: cover property (@(posedge pclk) disable iff (!presetn) trap_fire && !trap_user_r);
  c_return: cover property (@(posedge pclk) disable iff (!presetn) svc_return);

endmodule

/* testbench/vit_seq_model.sv */
module vit_seq_model
  import vit_pkg::*;
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Bench control
  input wire logic run,
  input wire logic nonint,
  // Sequencer side
  input wire logic take_valid,
  input wire logic [15:0] take_vector,
  output logic instr_done,
  output logic instr_is_branch,
  output logic instr_is_cache_loop,
  output logic instr_is_ptr_dec_only,
  // Observed branches
  output logic [7:0] take_cnt,
  output logic [15:0] last_vec
);
  timeunit 1ns;
  timeprecision 100ps;

  logic [1:0] kind_r;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      instr_done <= 1'h0;
      kind_r <= 2'h0;
      take_cnt <= 8'h00;
      last_vec <= 16'h0000;
    end else begin
      instr_done <= run;
      kind_r <= (kind_r == 2'h2) ? 2'h0 : kind_r + 2'h1;
      if (take_valid) begin
        take_cnt <= take_cnt + 8'h01;
        last_vec <= take_vector;
      end
    end
  end

  assign instr_is_branch = nonint && kind_r == 2'h0;
  assign instr_is_cache_loop = nonint && kind_r == 2'h1;
  assign instr_is_ptr_dec_only = nonint && kind_r == 2'h2;
endmodule

/* testbench/test_vectored_interrupt_trap_unit.sv */
module test_vectored_interrupt_trap_unit;
  import vit_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;

  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, perr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic run, nonint, trap_r, drv_r, take_valid, trap_active, ack, pin_out, pin_oe;
  logic instr_done, ib, icl, ipd;
  logic [19:0] strb;
  logic [3:0] code;
  logic [15:0] take_vector, last_vec;
  logic [7:0] take_cnt;
  int num_errors, checks, n;

  vit_top DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .instr_done(instr_done), .instr_is_branch(ib), .instr_is_cache_loop(icl), .instr_is_ptr_dec_only(ipd),
    .return_issued(strb[17]), .sw_irq_req(strb[18]), .debug_trap_req(strb[19]),
    .take_valid(take_valid), .take_vector(take_vector),
    .external_irq_pin_a(strb[0]), .test_port_irq(strb[1]), .external_irq_pin_b(strb[2]),
    .timer_irq(strb[3]), .serial_b_input_full_irq(strb[4]), .serial_b_output_empty_irq(strb[5]),
    .serial_a_input_full_irq(strb[6]), .serial_a_output_empty_irq(strb[7]),
    .host_port_input_full_irq(strb[8]), .host_port_output_empty_irq(strb[9]),
    .host_in_data_read(strb[10]), .host_out_data_write(strb[11]), .serial_a_in_data_read(strb[12]),
    .serial_a_out_data_write(strb[13]), .serial_b_in_data_read(strb[14]),
    .serial_b_out_data_write(strb[15]), .test_port_data_read(strb[16]),
    .trap_pin_in(trap_r), .trap_pin_drive(drv_r), .trap_pin_out(pin_out), .trap_pin_oe(pin_oe),
    .service_acknowledge_out(ack), .service_code_pins(code), .trap_active(trap_active));

  vit_seq_model seq (.pclk(pclk), .presetn(presetn), .run(run), .nonint(nonint),
    .take_valid(take_valid), .take_vector(take_vector), .instr_done(instr_done),
    .instr_is_branch(ib), .instr_is_cache_loop(icl), .instr_is_ptr_dec_only(ipd),
    .take_cnt(take_cnt), .last_vec(last_vec));

  initial begin
    pclk = 1'h0;
    forever #12.5 pclk = ~pclk;
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string msg);
    checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("mismatch at %0t: %s got %h expected %h", $time, msg, seen, exp);
    end
  endtask

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge pclk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'h1 && k < 50);
    rd = prdata;
    perr = pslverr;
    if (k >= 50) num_errors++;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask

  task automatic pulse(input int i);
    @(posedge pclk);
    strb[i] <= 1'h1;
    @(posedge pclk);
    strb[i] <= 1'h0;
  endtask

  task automatic take_is(input int cnt, input logic [15:0] vec, input logic [3:0] c);
    chk(32'(take_cnt), 32'(cnt), "take count");
    chk(32'(last_vec), 32'(vec), "vector");
    chk(32'(code), 32'(c), "service code");
  endtask

  task automatic print_verdict;
    $display("checks %0d num_errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  initial begin
    #(25 * 3000);
    num_errors++;
    print_verdict;
  end

  initial begin
    {presetn, psel, penable, pwrite, run, nonint, trap_r, drv_r} = '0;
    paddr = 12'h000;
    pwdata = 32'h00000000;
    strb = '0;
    repeat (6) @(posedge pclk);
    presetn <= 1'h1;
    run <= 1'h1;
    apb(1'h0, VIT_OFS_ENABLE, 32'h0);
    chk(rd, 32'h0, "enable after reset");
    apb(1'h0, VIT_OFS_STATUS, 32'h0);
    chk(rd, 32'h0, "status after reset");
    chk({ack, code, pin_oe}, 32'h0, "pins after reset");
    apb(1'h0, 12'h00C, 32'h0);
    chk(32'(perr), 32'h1, "unmapped error");
    chk(rd, 32'h0, "unmapped read");
    pulse(VIT_BIT_TIMER);
    repeat (4) @(posedge pclk);
    apb(1'h0, VIT_OFS_STATUS, 32'h0);
    chk(rd, 32'h8, "masked flag");
    chk(32'(take_cnt), 32'h0, "masked taken");
    nonint <= 1'h1;
    apb(1'h1, VIT_OFS_ENABLE, 32'h8);
    repeat (6) @(posedge pclk);
    chk(32'(take_cnt), 32'h0, "uninterruptible taken");
    nonint <= 1'h0;
    repeat (4) @(posedge pclk);
    take_is(1, 16'h0010, 4'hC);
    chk(32'(ack), 32'h1, "ack on entry");
    pulse(VIT_BIT_EXT_A);
    pulse(VIT_BIT_HOST_OUT);
    apb(1'h1, VIT_OFS_ENABLE, 32'h209);
    apb(1'h0, VIT_OFS_ENABLE, 32'h0);
    chk(rd, 32'h209, "enable read back");
    repeat (4) @(posedge pclk);
    chk(32'(take_cnt), 32'h1, "nested take");
    run <= 1'h0;
    pulse(17);
    #1 chk({ack, code}, 32'h0, "ack after return");
    apb(1'h0, VIT_OFS_STATUS, 32'h0);
    chk(rd, 32'h201, "status after return");
    run <= 1'h1;
    repeat (4) @(posedge pclk);
    take_is(2, 16'h0038, 4'h6);
    pulse(11);
    apb(1'h0, VIT_OFS_STATUS, 32'h0);
    chk(rd, 32'h001, "host out cleared");
    run <= 1'h0;
    pulse(17);
    run <= 1'h1;
    repeat (4) @(posedge pclk);
    take_is(3, 16'h0001, 4'h2);
    run <= 1'h0;
    pulse(17);
    apb(1'h1, VIT_OFS_ENABLE, 32'h0);
    pulse(VIT_BIT_SB_IN);
    pulse(VIT_BIT_SA_IN);
    pulse(VIT_BIT_TEST);
    pulse(VIT_BIT_EXT_B);
    pulse(VIT_BIT_HOST_IN);
    apb(1'h1, VIT_OFS_STATUS, 32'h3FF);
    apb(1'h0, VIT_OFS_STATUS, 32'h0);
    chk(rd, 32'h152, "write one clear");
    pulse(12);
    pulse(16);
    pulse(10);
    pulse(14);
    @(posedge pclk);
    apb(1'h1, VIT_OFS_STATUS, 32'h1);
    apb(1'h0, VIT_OFS_STATUS, 32'h0);
    chk(rd, 32'h0, "access clears");
    run <= 1'h1;
    pulse(18);
    repeat (4) @(posedge pclk);
    take_is(4, 16'h0002, 4'h1);
    apb(1'h0, VIT_OFS_SVC, 32'h0);
    chk(rd, 32'h15, "service state in irq");
    nonint <= 1'h1;
    pulse(19);
    repeat (7) @(posedge pclk);
    take_is(5, VIT_VEC_DEBUG_TRAP, 4'h1);
    chk({ack, trap_active}, 32'h3, "debug trap state");
    pulse(17);
    #1 chk({ack, trap_active}, 32'h2, "debug trap return");
    pulse(17);
    #1 chk(32'(ack), 32'h0, "service return");
    nonint <= 1'h0;
    @(posedge pclk);
    trap_r <= 1'h1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (take_valid !== 1'h1 && n < 20);
    chk(32'(n), 32'(VIT_TRAP_LAT_CYC + 2), "trap latency");
    #1 take_is(6, VIT_VEC_USER_TRAP, VIT_CODE_USER_TRAP);
    chk(32'(ack), 32'h1, "user trap ack");
    apb(1'h0, VIT_OFS_SVC, 32'h0);
    chk(rd, 32'h73, "service state in trap");
    pulse(19);
    trap_r <= 1'h0;
    @(posedge pclk);
    trap_r <= 1'h1;
    repeat (8) @(posedge pclk);
    chk(32'(take_cnt), 32'h6, "trap in trap");
    pulse(17);
    #1 chk({ack, code, trap_active}, 32'h0, "user trap return");
    drv_r <= 1'h1;
    repeat (2) @(posedge pclk);
    #1 chk({pin_out, pin_oe}, 32'h3, "trap pin drive");
    print_verdict;
  end
endmodule
